// ---- shared/abs_pkg.sv ----
// Shared constants, types and arithmetic for the add and bit-skip execute block
package abs_pkg;

  // ****************************************************************
  // Widths and sizes
  // ****************************************************************
  localparam int ABS_DATA_W = 8; // Accumulator and file register width
  localparam int ABS_ADDR_W = 7; // File register address width
  localparam int ABS_BIT_W = 3; // Bit index width
  localparam int ABS_FILE_DEPTH = 128; // Number of file registers

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int ABS_TCY_OSC_PERIODS = 4; // Clock periods per instruction cycle
  localparam logic [1:0] ABS_PHASE_LAST = 2'(ABS_TCY_OSC_PERIODS - 1); // Phase that ends a cycle
  localparam logic [1:0] ABS_PHASE_RESET = 2'h0; // Phase after reset

  // ****************************************************************
  // Reset values and field positions
  // ****************************************************************
  localparam logic [7:0] ABS_ACC_RESET = 8'h00; // Accumulator after reset
  localparam logic [7:0] ABS_FILE_RESET = 8'h00; // Each file register after reset
  localparam int ABS_NIBBLE_W = 4; // Digit carry leaves this many low bits

  // ****************************************************************
  // Operations, states and carriers
  // ****************************************************************
  typedef enum logic [2:0]
  {
    OP_SUM_IMMEDIATE_INTO_ACCUMULATOR = 3'h0,
    OP_SUM_ACCUMULATOR_WITH_REGISTER = 3'h1,
    OP_MASK_ACCUMULATOR_BY_IMMEDIATE = 3'h2,
    OP_MASK_ACCUMULATOR_WITH_REGISTER = 3'h3,
    OP_CLEAR_SELECTED_BIT = 3'h4,
    OP_SET_SELECTED_BIT = 3'h5,
    OP_TEST_BIT_SKIP_WHEN_ONE = 3'h6,
    OP_TEST_BIT_SKIP_WHEN_ZERO = 3'h7
  } abs_op_t;

  typedef enum logic [1:0]
  {
    ST_EXEC = 2'b01, // Normal instruction cycle
    ST_NOP = 2'b10 // Cycle whose instruction is discarded
  } abs_state_t;

  typedef struct packed
  {
    abs_op_t op; // Operation
    logic dest; // 0 accumulator, 1 file register
    logic [ABS_ADDR_W-1:0] file_addr; // File register address
    logic [ABS_BIT_W-1:0] bit_sel; // Bit index
    logic [ABS_DATA_W-1:0] literal; // Immediate value
  } abs_instr_t;

  typedef struct packed
  {
    logic zero; // Result was zero
    logic nibble_overflow_bit; // Carry out of bit 3
    logic carry; // Carry out of bit 7
  } abs_flags_t;

  // Sum with carry and digit carry: {carry, digit, sum}
  function automatic logic [9:0] abs_add(input logic [7:0] a, input logic [7:0] b);
    logic [8:0] full;
    logic [4:0] low;
    full = {1'b0, a} + {1'b0, b};
    low = {1'b0, a[ABS_NIBBLE_W-1:0]} + {1'b0, b[ABS_NIBBLE_W-1:0]};
    return {full[8], low[ABS_NIBBLE_W], full[7:0]};
  endfunction

endpackage

// ---- verif/tb_top.sv ----
// Self-checking bench for the add and bit-skip execute block
`timescale 1ns/100ps
module tb_top;
  import abs_pkg::*;
  // ****************************************************************
  // Clock, reset and stimulus signals
  // ****************************************************************
  logic clk_in = 1'b0; // Core clock
  logic rst_n_in = 1'b0; // Reset, held low at start
  logic instr_valid_in = 1'b0; // Instruction present
  abs_instr_t instr_in = '0; // Instruction fields
  logic load_en_in = 1'b0; // File load strobe
  logic [ABS_ADDR_W-1:0] load_addr_in = '0; // File load address
  logic [ABS_DATA_W-1:0] load_data_in = '0; // File load data
  logic [ABS_ADDR_W-1:0] peek_addr_in = '0; // File read address
  logic [ABS_DATA_W-1:0] accumulator_out; // Accumulator seen
  abs_flags_t flags_out; // Flags seen
  logic [ABS_DATA_W-1:0] peek_data_out; // File value seen
  logic cycle_end_out, retired_out, discarded_out, nop_cycle_out; // Cycle pulses
  int errors = 0; // Mismatch count
  int comparisons = 0; // Compare count
  logic [31:0] rng = 32'h0000_9818; // Fixed seed
  logic [7:0] ref_mem [ABS_FILE_DEPTH]; // Expected file contents
  logic [7:0] ref_acc = 8'h00; // Expected accumulator
  abs_flags_t ref_flags = '0; // Expected flags
  logic skip_pending = 1'b0; // Next cycle is a skip NOP
  // Half period of 20 ns
  always #20 clk_in = ~clk_in;
  abs_execute i_abs_execute (.clk_in(clk_in), .rst_n_in(rst_n_in), .instr_valid_in(instr_valid_in),
    .instr_in(instr_in), .load_en_in(load_en_in), .load_addr_in(load_addr_in), .load_data_in(load_data_in),
    .peek_addr_in(peek_addr_in), .accumulator_out(accumulator_out), .flags_out(flags_out),
    .peek_data_out(peek_data_out), .cycle_end_out(cycle_end_out), .retired_out(retired_out),
    .discarded_out(discarded_out), .nop_cycle_out(nop_cycle_out));
  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Step the xorshift random source
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  // Compare and report
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic tally_and_finish();
    if (errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Build one instruction
  function automatic abs_instr_t mk(abs_op_t op, logic d, logic [6:0] a, logic [2:0] b, logic [7:0] k);
    return '{op: op, dest: d, file_addr: a, bit_sel: b, literal: k};
  endfunction
  // ****************************************************************
  // One instruction cycle with expected results
  // ****************************************************************
  task automatic run_cycle(input abs_instr_t ins, input logic vld);
    logic [8:0] full;
    logic [4:0] low;
    logic [7:0] opd;
    logic [7:0] res;
    logic was_skip;
    was_skip = skip_pending;
    check("nop_cycle", 8'(nop_cycle_out), 8'(was_skip));
    instr_in = ins;
    instr_valid_in = vld;
    @(posedge clk_in);
    #1;
    // Write of the previous cycle is readable now
    check("file", peek_data_out, ref_mem[peek_addr_in]);
    peek_addr_in = ins.file_addr;
    @(posedge clk_in);
    #1;
    check("acc_hold", accumulator_out, ref_acc);
    // Take edge is the fourth clock of the cycle
    repeat (2) @(posedge clk_in);
    #1;
    skip_pending = 1'b0;
    res = 8'h00;
    // Immediate or file operand
    opd = (ins.op inside {OP_SUM_IMMEDIATE_INTO_ACCUMULATOR, OP_MASK_ACCUMULATOR_BY_IMMEDIATE}) ?
      ins.literal : ref_mem[ins.file_addr];
    if (vld && !was_skip)
    begin
      full = {1'b0, ref_acc} + {1'b0, opd};
      low = {1'b0, ref_acc[3:0]} + {1'b0, opd[3:0]};
      case (ins.op)
        OP_SUM_IMMEDIATE_INTO_ACCUMULATOR, OP_SUM_ACCUMULATOR_WITH_REGISTER:
        begin
          res = full[7:0];
          ref_flags = '{zero: res == 8'h00, nibble_overflow_bit: low[4], carry: full[8]};
        end
        OP_MASK_ACCUMULATOR_BY_IMMEDIATE, OP_MASK_ACCUMULATOR_WITH_REGISTER:
        begin
          res = ref_acc & opd;
          ref_flags.zero = (res == 8'h00);
        end
        OP_CLEAR_SELECTED_BIT: ref_mem[ins.file_addr][ins.bit_sel] = 1'b0;
        OP_SET_SELECTED_BIT: ref_mem[ins.file_addr][ins.bit_sel] = 1'b1;
        OP_TEST_BIT_SKIP_WHEN_ONE: skip_pending = opd[ins.bit_sel];
        default: skip_pending = !opd[ins.bit_sel];
      endcase
      // Result routing by destination
      if (ins.op inside {OP_SUM_IMMEDIATE_INTO_ACCUMULATOR, OP_MASK_ACCUMULATOR_BY_IMMEDIATE})
        ref_acc = res;
      else if (ins.op inside {OP_SUM_ACCUMULATOR_WITH_REGISTER, OP_MASK_ACCUMULATOR_WITH_REGISTER})
      begin
        if (ins.dest)
          ref_mem[ins.file_addr] = res;
        else
          ref_acc = res;
      end
    end
    check("accumulator", accumulator_out, ref_acc);
    check("flags", 8'(flags_out), 8'(ref_flags));
    check("cycle_end", 8'(cycle_end_out), 8'h01);
    check("retired", 8'(retired_out), 8'(vld && !was_skip));
    check("discarded", 8'(discarded_out), 8'(vld && was_skip));
  endtask
  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    repeat (4) @(posedge clk_in);
    #1;
    rst_n_in = 1'b1;
    // Fill the file with random bytes
    for (int a = 0; a < ABS_FILE_DEPTH; a++)
    begin
      rng = xorshift(rng);
      load_en_in = 1'b1;
      load_addr_in = 7'(a);
      load_data_in = rng[7:0];
      ref_mem[a] = rng[7:0];
      @(posedge clk_in);
      #1;
    end
    load_en_in = 1'b0;
    // Align to the end of an instruction cycle
    for (int n = 0; n < 8 && cycle_end_out !== 1'b1; n++)
    begin
      @(posedge clk_in);
      #1;
    end
    if (cycle_end_out !== 1'b1)
    begin
      errors++;
      tally_and_finish();
    end
    // Carry, digit carry and zero corners
    run_cycle(mk(OP_SUM_IMMEDIATE_INTO_ACCUMULATOR, 1'b0, 7'h00, 3'h0, 8'h0f), 1'b1);
    run_cycle(mk(OP_SUM_IMMEDIATE_INTO_ACCUMULATOR, 1'b0, 7'h00, 3'h0, 8'h01), 1'b1);
    run_cycle(mk(OP_SUM_IMMEDIATE_INTO_ACCUMULATOR, 1'b0, 7'h00, 3'h0, 8'hf0), 1'b1);
    run_cycle(mk(OP_MASK_ACCUMULATOR_BY_IMMEDIATE, 1'b0, 7'h00, 3'h0, 8'hff), 1'b1);
    run_cycle(mk(OP_SUM_ACCUMULATOR_WITH_REGISTER, 1'b1, 7'h7f, 3'h0, 8'h00), 1'b1);
    run_cycle(mk(OP_MASK_ACCUMULATOR_WITH_REGISTER, 1'b1, 7'h7f, 3'h0, 8'h00), 1'b1);
    // Skip taken, then a skip discarded in the NOP cycle
    run_cycle(mk(OP_SET_SELECTED_BIT, 1'b0, 7'h06, 3'h7, 8'h00), 1'b1);
    run_cycle(mk(OP_TEST_BIT_SKIP_WHEN_ONE, 1'b0, 7'h06, 3'h7, 8'h00), 1'b1);
    run_cycle(mk(OP_TEST_BIT_SKIP_WHEN_ONE, 1'b0, 7'h06, 3'h7, 8'h00), 1'b1);
    run_cycle(mk(OP_CLEAR_SELECTED_BIT, 1'b0, 7'h06, 3'h0, 8'h00), 1'b1);
    run_cycle(mk(OP_TEST_BIT_SKIP_WHEN_ZERO, 1'b0, 7'h06, 3'h0, 8'h00), 1'b1);
    run_cycle(mk(OP_SUM_IMMEDIATE_INTO_ACCUMULATOR, 1'b0, 7'h00, 3'h0, 8'h33), 1'b0);
    run_cycle(mk(OP_TEST_BIT_SKIP_WHEN_ZERO, 1'b0, 7'h06, 3'h7, 8'h00), 1'b1);
    // Random instruction stream
    for (int i = 0; i < 300; i++)
    begin
      rng = xorshift(rng);
      run_cycle(abs_instr_t'(rng[21:0]), rng[24:22] != 3'h0);
    end
    // Last file write of the stream
    @(posedge clk_in);
    #1;
    check("file", peek_data_out, ref_mem[peek_addr_in]);
    tally_and_finish();
  end
  // Hang guard, well beyond the expected run
  initial
  begin
    #(40 * 8000);
    errors++;
    tally_and_finish();
  end
endmodule

// ---- verilog/abs_execute.sv ----
// Execute unit for add, mask, bit set/clear and bit-test-skip instructions
//
// Overview of operation
// RULE1: Immediate add into accumulator, flags C DC Z
// RULE2: Accumulator plus file register, flags C DC Z
// RULE3: Register ops: dest 0 accumulator, 1 file
// RULE4: Immediate mask into accumulator, zero flag only
// RULE5: Register mask, routed by dest, zero only
// RULE6: Clear selected file bit, flags untouched
// RULE7: Set selected file bit, flags untouched
// RULE8: Skip next instruction when tested bit one
// RULE9: Skip next instruction when tested bit zero
// RULE10: Instruction cycle is four clocks; skip adds NOP
// RULE11: Digit carry from bit 3; zero on zero result
`timescale 1ns/100ps
module abs_execute
  import abs_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic instr_valid_in,
  input wire abs_instr_t instr_in,
  input wire logic load_en_in,
  input wire logic [ABS_ADDR_W-1:0] load_addr_in,
  input wire logic [ABS_DATA_W-1:0] load_data_in,
  input wire logic [ABS_ADDR_W-1:0] peek_addr_in,
  output logic [ABS_DATA_W-1:0] accumulator_out,
  output abs_flags_t flags_out,
  output logic [ABS_DATA_W-1:0] peek_data_out,
  output logic cycle_end_out,
  output logic retired_out,
  output logic discarded_out,
  output logic nop_cycle_out
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [ABS_DATA_W-1:0] file_mem [ABS_FILE_DEPTH]; // File registers
  logic [1:0] phase_q, phase_d; // Clock phase within instruction cycle
  logic tcy_en; // Last phase of instruction cycle
  abs_state_t state_q, state_d; // Execute or discard
  logic [ABS_DATA_W-1:0] acc_q, acc_d; // Accumulator
  abs_flags_t flags_q, flags_d; // Status flags
  logic [ABS_DATA_W-1:0] peek_q; // Registered peek read
  logic cycle_end_q; // Cycle boundary pulse
  logic retired_q, retired_d; // Instruction executed pulse
  logic discarded_q, discarded_d; // Instruction discarded pulse
  logic nop_q; // Current cycle is a skip NOP
  logic wr_en; // File write strobe
  logic [ABS_ADDR_W-1:0] wr_addr; // File write address
  logic [ABS_DATA_W-1:0] wr_data; // File write data
  logic [ABS_DATA_W-1:0] file_val; // Addressed file register
  logic [9:0] add_res; // Adder output {C, DC, sum}
  logic [ABS_DATA_W-1:0] result; // Result of a register op
  logic bit_val; // Tested bit

  // ****************************************************************
  // Instruction cycle divider
  // ****************************************************************
  // Phase counter wraps after the last phase
  always_comb
  begin
    tcy_en = (phase_q == ABS_PHASE_LAST); // [RULE10]
    if (tcy_en)
    begin
      phase_d = ABS_PHASE_RESET;
    end
    else
    begin
      phase_d = phase_q + 2'h1;
    end
  end

  // Phase register
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      phase_q <= ABS_PHASE_RESET;
      cycle_end_q <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      cycle_end_q <= tcy_en;
    end
  end

  // ****************************************************************
  // Execute
  // ****************************************************************
  // Next accumulator, flags, file write and skip state
  always_comb
  begin
    file_val = file_mem[instr_in.file_addr];
    bit_val = file_val[instr_in.bit_sel];
    add_res = abs_add(acc_q, file_val);
    result = file_val;
    acc_d = acc_q;
    flags_d = flags_q;
    state_d = state_q;
    retired_d = 1'b0;
    discarded_d = 1'b0;
    wr_en = load_en_in;
    wr_addr = load_addr_in;
    wr_data = load_data_in;
    if (tcy_en && (state_q == ST_NOP))
    begin
      // Skipped slot runs as a NOP
      discarded_d = instr_valid_in; // [RULE8] [RULE9]
      state_d = ST_EXEC; // [RULE10]
    end
    else if (tcy_en && instr_valid_in)
    begin
      retired_d = 1'b1;
      case (instr_in.op)
        OP_SUM_IMMEDIATE_INTO_ACCUMULATOR:
        begin
          add_res = abs_add(acc_q, instr_in.literal);
          acc_d = add_res[7:0]; // [RULE1]
          flags_d.carry = add_res[9];
          flags_d.nibble_overflow_bit = add_res[8]; // [RULE11]
          flags_d.zero = (add_res[7:0] == 8'h00); // [RULE11]
        end
        OP_SUM_ACCUMULATOR_WITH_REGISTER:
        begin
          result = add_res[7:0]; // [RULE2]
          flags_d.carry = add_res[9];
          flags_d.nibble_overflow_bit = add_res[8]; // [RULE11]
          flags_d.zero = (add_res[7:0] == 8'h00); // [RULE11]
        end
        OP_MASK_ACCUMULATOR_BY_IMMEDIATE:
        begin
          acc_d = acc_q & instr_in.literal; // [RULE4]
          flags_d.zero = ((acc_q & instr_in.literal) == 8'h00); // [RULE4]
        end
        OP_MASK_ACCUMULATOR_WITH_REGISTER:
        begin
          result = acc_q & file_val; // [RULE5]
          flags_d.zero = ((acc_q & file_val) == 8'h00); // [RULE5]
        end
        OP_CLEAR_SELECTED_BIT:
        begin
          wr_data = file_val & ~(8'h01 << instr_in.bit_sel); // [RULE6]
          wr_addr = instr_in.file_addr;
          wr_en = 1'b1;
        end
        OP_SET_SELECTED_BIT:
        begin
          wr_data = file_val | (8'h01 << instr_in.bit_sel); // [RULE7]
          wr_addr = instr_in.file_addr;
          wr_en = 1'b1;
        end
        OP_TEST_BIT_SKIP_WHEN_ONE:
        begin
          if (bit_val)
          begin
            state_d = ST_NOP; // [RULE8]
          end
        end
        OP_TEST_BIT_SKIP_WHEN_ZERO:
        begin
          if (!bit_val)
          begin
            state_d = ST_NOP; // [RULE9]
          end
        end
        default:
        begin
          retired_d = 1'b0;
        end
      endcase
      // Register ops route their result by the destination bit
      if ((instr_in.op == OP_SUM_ACCUMULATOR_WITH_REGISTER) ||
          (instr_in.op == OP_MASK_ACCUMULATOR_WITH_REGISTER))
      begin
        if (instr_in.dest)
        begin
          wr_en = 1'b1; // [RULE3]
          wr_addr = instr_in.file_addr;
          wr_data = result;
        end
        else
        begin
          acc_d = result; // [RULE3]
        end
      end
    end
  end

  // Execute registers
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= ST_EXEC;
      acc_q <= ABS_ACC_RESET;
      flags_q <= '0;
      retired_q <= 1'b0;
      discarded_q <= 1'b0;
      nop_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      acc_q <= acc_d;
      flags_q <= flags_d;
      retired_q <= retired_d;
      discarded_q <= discarded_d;
      nop_q <= (state_d == ST_NOP);
    end
  end

  // File registers; instruction write beats a load in the same clock
  always_ff @(posedge clk_in)
  begin
    if (!rst_n_in)
    begin
      for (int i = 0; i < ABS_FILE_DEPTH; i++)
      begin
        file_mem[i] <= ABS_FILE_RESET;
      end
      peek_q <= ABS_FILE_RESET;
    end
    else
    begin
      if (wr_en)
      begin
        file_mem[wr_addr] <= wr_data;
      end
      peek_q <= file_mem[peek_addr_in];
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign accumulator_out = acc_q;
  assign flags_out = flags_q;
  assign peek_data_out = peek_q;
  assign cycle_end_out = cycle_end_q;
  assign retired_out = retired_q;
  assign discarded_out = discarded_q;
  assign nop_cycle_out = nop_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic go; // Instruction executes this clock
  assign go = tcy_en && (state_q == ST_EXEC) && instr_valid_in;

  sum_immediate_acc_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE1]
    go && (instr_in.op == OP_SUM_IMMEDIATE_INTO_ACCUMULATOR)
    |=> acc_q == 8'($past(acc_q) + $past(instr_in.literal)))
    else $error("immediate sum wrong");

  sum_register_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE2]
    go && (instr_in.op == OP_SUM_ACCUMULATOR_WITH_REGISTER)
    |=> flags_q.zero == (8'($past(acc_q) + $past(file_val)) == 8'h00))
    else $error("register sum zero flag wrong");

  dest_file_keeps_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE3]
    go && instr_in.dest && (instr_in.op == OP_MASK_ACCUMULATOR_WITH_REGISTER)
    |=> $stable(acc_q) && (file_mem[$past(instr_in.file_addr)] == ($past(acc_q) & $past(file_val))))
    else $error("file destination result wrong");

  mask_immediate_carry_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE4]
    go && (instr_in.op == OP_MASK_ACCUMULATOR_BY_IMMEDIATE)
    |=> $stable(flags_q.carry) && $stable(flags_q.nibble_overflow_bit)
        && acc_q == ($past(acc_q) & $past(instr_in.literal)))
    else $error("immediate mask wrong");

  mask_register_acc_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE5]
    go && !instr_in.dest && (instr_in.op == OP_MASK_ACCUMULATOR_WITH_REGISTER)
    |=> acc_q == ($past(acc_q) & $past(file_val)) && $stable(flags_q.carry))
    else $error("register mask wrong");

  clear_bit_flags_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE6]
    go && (instr_in.op == OP_CLEAR_SELECTED_BIT)
    |=> $stable(flags_q) && $stable(acc_q))
    else $error("bit clear touched flags");

  set_bit_flags_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE7]
    go && (instr_in.op == OP_SET_SELECTED_BIT)
    |=> $stable(flags_q) && $stable(acc_q))
    else $error("bit set touched flags");

  skip_when_one_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE8]
    go && (instr_in.op == OP_TEST_BIT_SKIP_WHEN_ONE)
    |=> (nop_q == $past(bit_val)) ##4 (!nop_q || !$past(bit_val, 5)))
    else $error("skip when one wrong");

  skip_when_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE9]
    go && (instr_in.op == OP_TEST_BIT_SKIP_WHEN_ZERO)
    |=> (nop_q == !$past(bit_val)) ##4 (!nop_q || $past(bit_val, 5)))
    else $error("skip when zero wrong");

  cycle_four_clocks_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE10]
    tcy_en |=> !tcy_en [*3] ##1 tcy_en)
    else $error("instruction cycle not four clocks");

  digit_carry_a: assert property (@(posedge clk_in) disable iff (!rst_n_in) // [RULE11]
    go && (instr_in.op == OP_SUM_IMMEDIATE_INTO_ACCUMULATOR)
    |=> flags_q.nibble_overflow_bit ==
        (({1'b0, $past(acc_q[3:0])} + {1'b0, $past(instr_in.literal[3:0])}) > 5'h0f))
    else $error("digit carry wrong");

endmodule
